// ---- design/tmr2_edge_sync.sv ----
// two-flop synchroniser with falling-edge detector for one pin
// assumes the pin is asynchronous to sys_clk
`timescale 1ns/1ns
module tmr2_edge_sync (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic pin,
  output logic level,
  output logic fall
);

  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
      prev_reg <= 1'b1;
    end else begin
      meta_reg <= pin;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign level = sync_reg;
  assign fall = prev_reg & ~sync_reg;

endmodule

// ---- design/tmr2_top.sv ----
// 16-bit timer/counter: capture, auto-reload, baud clock, clock-out
// assumes an AXI4-Lite master on sys_clk and asynchronous pins
//
// How it works
// - sixteen-bit counter counts internal pulses or external events per select bit.
// - run off stops it; serial selects give baud; else reload or capture.
// - capture mode without external enable counts freely, flags each overflow.
// - capture with external enable: trigger fall copies count, sets external flag.
// - capture mode never reloads; counting goes on after a capture.
// - both flags share one interrupt request, gated by the interrupt enable; the external flag only while down-count enable is clear.
// - reset clears down-count enable so reload mode counts up.
// - up-only reload counts to FFFF, flags overflow, reloads capture value.
// - with external enable a trigger fall also reloads and sets external flag.
// - up/down mode, trigger high: count up, overflow at FFFF reloads.
// - up/down mode, trigger low: count down, at capture value load FFFF.
// - up/down mode toggles external flag per wrap; that flag raises no interrupt there.
// - clock-out frequency is clock over four times (65536 minus capture).
// - clock-out rollovers raise no interrupt, as in baud generation.
// - baud clock and clock-out may run together; baud pulses come at twice the clock-out frequency.
// - counter mode counts pin falls; timer mode counts clock over twelve, or over two in baud and clock-out.
// - receive clock select picks this overflow or the other timer's.
`timescale 1ns/1ns
module tmr2_top (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic count_pin_in,
  input wire logic external_trigger_pin,
  output logic clock_output_pin_out,
  output logic clock_output_pin_oe,
  input wire logic other_timer_overflow,
  output logic rx_bit_clock,
  output logic tx_bit_clock,
  output logic timer_irq
);

  ////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [15:0] merge16(
    input logic [15:0] old,
    input logic [31:0] data,
    input logic [3:0] strb
  );
    logic [15:0] res;
    res = old;
    if (strb[0]) begin
      res[7:0] = data[7:0];
    end
    if (strb[1]) begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction

  function automatic logic addr_known(input logic [4:0] a);
    return a == tmr2_pkg::ADDR_CONTROL || a == tmr2_pkg::ADDR_MODE ||
      a == tmr2_pkg::ADDR_COUNT || a == tmr2_pkg::ADDR_CAPTURE ||
      a == tmr2_pkg::ADDR_IRQ_EN;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // register bus

  logic aw_held_reg;
  logic w_held_reg;
  logic [4:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic wr_fire;
  logic [7:0] control_reg;
  logic [1:0] mode_reg;
  logic [15:0] count_reg;
  logic [15:0] capture_reg;
  logic irq_en_reg;

  assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 5'h00;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_held_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr[4:0];
    end else if (!aw_held_reg && !s_axi_bvalid) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_axi_wready <= 1'b1;
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
    end else if (wr_fire) begin
      w_held_reg <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_held_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end else if (!w_held_reg && !s_axi_bvalid) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= tmr2_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= addr_known(aw_addr_reg) ?
        tmr2_pkg::RESP_OKAY : tmr2_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  logic wr_control;
  logic wr_mode;
  logic wr_count;
  logic wr_capture;
  logic wr_irq_en;

  assign wr_control = wr_fire && w_strb_reg[0] &&
    aw_addr_reg == tmr2_pkg::ADDR_CONTROL;
  assign wr_mode = wr_fire && w_strb_reg[0] &&
    aw_addr_reg == tmr2_pkg::ADDR_MODE;
  assign wr_count = wr_fire && aw_addr_reg == tmr2_pkg::ADDR_COUNT;
  assign wr_capture = wr_fire && aw_addr_reg == tmr2_pkg::ADDR_CAPTURE;
  assign wr_irq_en = wr_fire && w_strb_reg[0] &&
    aw_addr_reg == tmr2_pkg::ADDR_IRQ_EN;

  logic [31:0] rd_word;

  always_comb begin
    rd_word = 32'h00000000;
    unique case (s_axi_araddr[4:0])
      tmr2_pkg::ADDR_CONTROL: rd_word[7:0] = control_reg;
      tmr2_pkg::ADDR_MODE: rd_word[1:0] = mode_reg;
      tmr2_pkg::ADDR_COUNT: rd_word[15:0] = count_reg;
      tmr2_pkg::ADDR_CAPTURE: rd_word[15:0] = capture_reg;
      tmr2_pkg::ADDR_IRQ_EN: rd_word[tmr2_pkg::IRQ_EN_BIT] = irq_en_reg;
      default: rd_word = 32'h00000000;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= tmr2_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= addr_known(s_axi_araddr[4:0]) ?
        tmr2_pkg::RESP_OKAY : tmr2_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pins and tick generation

  logic trig_level;
  logic trig_fall;
  logic cnt_fall;

  tmr2_edge_sync u_trig_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .pin(external_trigger_pin),
    .level(trig_level),
    .fall(trig_fall)
  );

  tmr2_edge_sync u_count_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .pin(count_pin_in),
    .level(),
    .fall(cnt_fall)
  );

  logic run;
  logic counter_sel;
  logic ext_en;
  logic down_en;
  logic clk_out_en;
  logic clk_out_mode;
  tmr2_pkg::tmr2_mode_t mode;

  assign run = control_reg[tmr2_pkg::CTL_RUN];
  assign counter_sel = control_reg[tmr2_pkg::CTL_COUNTER];
  assign ext_en = control_reg[tmr2_pkg::CTL_EXT_EN];
  assign down_en = mode_reg[tmr2_pkg::MOD_DOWN];
  assign clk_out_en = mode_reg[tmr2_pkg::MOD_CLK_OUT];
  assign clk_out_mode = clk_out_en && !counter_sel;

  always_comb begin
    if (!run) begin
      mode = tmr2_pkg::TMR2_OFF;
    end else if (control_reg[tmr2_pkg::CTL_RX_CLK] ||
      control_reg[tmr2_pkg::CTL_TX_CLK]) begin
      mode = tmr2_pkg::TMR2_BAUD;
    end else if (control_reg[tmr2_pkg::CTL_CAPTURE]) begin
      mode = tmr2_pkg::TMR2_CAPTURE;
    end else begin
      mode = tmr2_pkg::TMR2_RELOAD;
    end
  end

  logic fast;
  logic [3:0] prescale_reg;
  logic fast_reg;
  logic tick;

  assign fast = mode == tmr2_pkg::TMR2_BAUD || clk_out_mode;

  always_ff @(posedge sys_clk) begin
    if (rst || !run) begin
      prescale_reg <= 4'h0;
    end else if (prescale_reg == tmr2_pkg::PRESCALE_LAST) begin
      prescale_reg <= 4'h0;
    end else begin
      prescale_reg <= prescale_reg + 4'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst || !run) begin
      fast_reg <= 1'b0;
    end else begin
      fast_reg <= !fast_reg;
    end
  end

  always_comb begin
    if (mode == tmr2_pkg::TMR2_OFF) begin
      tick = 1'b0;
    end else if (counter_sel) begin
      tick = cnt_fall;
    end else if (fast) begin
      tick = fast_reg;
    end else begin
      tick = prescale_reg == tmr2_pkg::PRESCALE_LAST;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // counter and events

  logic at_top;
  logic up_dir;
  logic wrap;
  logic ext_event;
  logic [15:0] count_next;
  logic tf_set;
  logic exf_set;
  logic exf_flip;
  logic do_capture;

  assign at_top = count_reg == tmr2_pkg::COUNT_TOP;
  assign up_dir = !down_en || trig_level;
  assign ext_event = ext_en && trig_fall;

  always_comb begin
    count_next = count_reg;
    wrap = 1'b0;
    exf_set = 1'b0;
    exf_flip = 1'b0;
    do_capture = 1'b0;
    unique case (mode)
      tmr2_pkg::TMR2_OFF: begin
        count_next = count_reg;
      end
      tmr2_pkg::TMR2_CAPTURE: begin
        if (tick) begin
          count_next = count_reg + 16'h0001;
          wrap = at_top;
        end
        do_capture = ext_event;
        exf_set = ext_event;
      end
      tmr2_pkg::TMR2_BAUD: begin
        if (tick) begin
          wrap = at_top;
          count_next = at_top ? capture_reg : count_reg + 16'h0001;
        end
        exf_set = ext_event;
      end
      tmr2_pkg::TMR2_RELOAD: begin
        if (down_en) begin
          if (tick && up_dir) begin
            wrap = at_top;
            count_next = at_top ? capture_reg : count_reg + 16'h0001;
          end else if (tick) begin
            wrap = count_reg == capture_reg;
            count_next = wrap ? tmr2_pkg::COUNT_TOP :
              count_reg - 16'h0001;
          end
          exf_flip = wrap;
        end else begin
          if (tick) begin
            wrap = at_top;
            count_next = at_top ? capture_reg : count_reg + 16'h0001;
          end
          if (ext_event) begin
            count_next = capture_reg;
          end
          exf_set = ext_event;
        end
      end
    endcase
    tf_set = wrap && mode != tmr2_pkg::TMR2_BAUD && !clk_out_mode;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      count_reg <= tmr2_pkg::COUNT_RST;
    end else if (wr_count) begin
      count_reg <= merge16(count_reg, w_data_reg, w_strb_reg);
    end else begin
      count_reg <= count_next;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      capture_reg <= tmr2_pkg::CAPTURE_RST;
    end else if (do_capture) begin
      capture_reg <= count_reg;
    end else if (wr_capture) begin
      capture_reg <= merge16(capture_reg, w_data_reg, w_strb_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control, mode and enable registers

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      control_reg <= tmr2_pkg::CONTROL_RST;
    end else begin
      if (wr_control) begin
        control_reg <= w_data_reg[7:0];
      end
      if (tf_set) begin
        control_reg[tmr2_pkg::CTL_OVERFLOW] <= 1'b1;
      end
      if (exf_flip) begin
        control_reg[tmr2_pkg::CTL_EXTERNAL] <=
          !control_reg[tmr2_pkg::CTL_EXTERNAL];
      end else if (exf_set) begin
        control_reg[tmr2_pkg::CTL_EXTERNAL] <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mode_reg <= tmr2_pkg::MODE_RST;
    end else if (wr_mode) begin
      mode_reg <= w_data_reg[1:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_en_reg <= 1'b0;
    end else if (wr_irq_en) begin
      irq_en_reg <= w_data_reg[tmr2_pkg::IRQ_EN_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  logic bit_pulse;

  assign bit_pulse = wrap && (mode == tmr2_pkg::TMR2_BAUD || clk_out_mode);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      timer_irq <= 1'b0;
    end else begin
      timer_irq <= irq_en_reg && (control_reg[tmr2_pkg::CTL_OVERFLOW] ||
        (control_reg[tmr2_pkg::CTL_EXTERNAL] && !down_en));
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rx_bit_clock <= 1'b0;
      tx_bit_clock <= 1'b0;
    end else begin
      rx_bit_clock <= control_reg[tmr2_pkg::CTL_RX_CLK] ?
        (wrap && mode == tmr2_pkg::TMR2_BAUD) : other_timer_overflow;
      tx_bit_clock <= control_reg[tmr2_pkg::CTL_TX_CLK] ?
        (wrap && mode == tmr2_pkg::TMR2_BAUD) : other_timer_overflow;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      clock_output_pin_out <= 1'b0;
      clock_output_pin_oe <= 1'b0;
    end else begin
      clock_output_pin_oe <= clk_out_mode;
      if (!clk_out_mode) begin
        clock_output_pin_out <= 1'b0;
      end else if (bit_pulse) begin
        clock_output_pin_out <= !clock_output_pin_out;
      end
    end
  end

endmodule

// ---- dv/test_timer2_capture_reload_clockout.sv ----
// bench: random and corner scenarios over the register bus and pins
// assumes tmr2_top, its bound checker and the pin model
`timescale 1ns/1ns
module test_timer2_capture_reload_clockout;
  localparam logic [4:0] CTL = tmr2_pkg::ADDR_CONTROL;
  localparam logic [4:0] MDE = tmr2_pkg::ADDR_MODE;
  localparam logic [4:0] CNT = tmr2_pkg::ADDR_COUNT;
  localparam logic [4:0] CPR = tmr2_pkg::ADDR_CAPTURE;
  localparam logic [31:0] RUN = 1 << tmr2_pkg::CTL_RUN;
  localparam logic [31:0] CSEL = 1 << tmr2_pkg::CTL_COUNTER;
  localparam logic [31:0] CAPM = 1 << tmr2_pkg::CTL_CAPTURE;
  localparam logic [31:0] EXT = 1 << tmr2_pkg::CTL_EXT_EN;
  localparam logic [31:0] TXS = 1 << tmr2_pkg::CTL_TX_CLK;
  localparam logic [31:0] RXS = 1 << tmr2_pkg::CTL_RX_CLK;
  localparam logic [31:0] OVF = 1 << tmr2_pkg::CTL_OVERFLOW;
  localparam logic [31:0] EXF = 1 << tmr2_pkg::CTL_EXTERNAL;
  localparam logic [31:0] FF = 32'h0000FFFF;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, clock_output_pin_out, clock_output_pin_oe;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic count_pin_in, external_trigger_pin, other_timer_overflow;
  logic rx_bit_clock, tx_bit_clock, timer_irq;
  int num_errors = 0;
  int checks_done = 0;
  integer seed = 70;
  always #50 sys_clk = ~sys_clk;
  tmr2_top dut (.sys_clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .count_pin_in,
    .external_trigger_pin, .clock_output_pin_out, .clock_output_pin_oe,
    .other_timer_overflow, .rx_bit_clock, .tx_bit_clock, .timer_irq);
  tmr2_pin_model pins (.sys_clk, .count_pin_in, .external_trigger_pin,
    .other_timer_overflow);
  //////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    if (num_errors == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic fail();
    num_errors++;
    $display("BAD %0t timeout", $time);
    summarize();
  endtask
  task automatic chk(input logic ok, input string m);
    checks_done++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  function automatic int period(input logic [15:0] c);
    return 4 * (32'h10000 - c);
  endfunction
  task automatic wr(input logic [4:0] a, input logic [31:0] v,
      input logic [1:0] e = tmr2_pkg::RESP_OKAY,
      input logic [3:0] s = 4'hF);
    int n, dly;
    n = 0;
    dly = $unsigned($random(seed)) % 4;
    s_axi_awaddr <= {27'h0, a};
    s_axi_wdata <= v;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b0;
    do begin
      @(posedge sys_clk);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (n >= dly && s_axi_bready !== 1'b1) s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) && n < 50);
    if (n >= 50) fail();
    chk(s_axi_bresp === e, "write response");
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] d,
      output logic [1:0] r);
    int n, dly;
    n = 0;
    dly = $unsigned($random(seed)) % 4;
    s_axi_araddr <= {27'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b0;
    do begin
      @(posedge sys_clk);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (n >= dly && s_axi_rready !== 1'b1) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) && n < 50);
    if (n >= 50) fail();
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  task automatic rc(input logic [4:0] a, input logic [31:0] m, lo, hi);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk((d & m) >= lo && (d & m) <= hi && r === 2'h0, "read value");
  endtask
  task automatic gap(input int sel, output int g);
    int n;
    logic s, p;
    n = 0;
    s = 1'b1;
    for (int k = 0; k < 2; k++) begin
      g = 0;
      do begin
        @(posedge sys_clk);
        n++;
        g++;
        p = s;
        s = sel == 2 ? rx_bit_clock :
          sel == 1 ? tx_bit_clock : clock_output_pin_out;
      end while (!(s === 1'b1 && p === 1'b0) && n < 600);
    end
    if (n >= 600) fail();
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [15:0] cap;
    int g;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rc(CTL, '1, 0, 0);
    rc(MDE, '1, 0, 0);
    rd(5'h14, d, r);
    chk(d === 32'h0 && r === tmr2_pkg::RESP_SLVERR, "unmapped read");
    wr(5'h18, 32'h0000FFFF, tmr2_pkg::RESP_SLVERR);
    wr(CNT, 32'h0000ABCD);
    wr(CNT, 32'h00001234, tmr2_pkg::RESP_OKAY, 4'h1);
    wr(CTL, RUN, tmr2_pkg::RESP_OKAY, 4'h2);
    rc(CNT, FF, 32'h0000AB34, 32'h0000AB34);
    rc(CTL, '1, 0, 0);
    wr(CNT, 0);
    wr(CTL, RUN | CSEL);
    pins.falls(5);
    rc(CNT, FF, 5, 5);
    wr(CTL, 0);
    pins.falls(2);
    rc(CNT, FF, 5, 5);
    wr(CNT, 0);
    wr(CTL, RUN);
    repeat (120) @(posedge sys_clk);
    wr(CTL, 0);
    rc(CNT, FF, 9, 11);
    cap = 16'h1000 + 16'($random(seed) & 32'hFF);
    wr(CPR, cap);
    wr(CNT, 32'h0000FFFE);
    wr(tmr2_pkg::ADDR_IRQ_EN, 1);
    wr(CTL, RUN);
    repeat (40) @(posedge sys_clk);
    rc(CTL, OVF, OVF, OVF);
    chk(timer_irq === 1'b1, "overflow irq");
    rc(CNT, FF, cap, cap + 4);
    wr(CTL, 0);
    repeat (2) @(posedge sys_clk);
    chk(timer_irq === 1'b0, "irq after clear");
    wr(CNT, 32'h00000100);
    wr(CTL, RUN | EXT);
    pins.trig(1'b0);
    pins.trig(1'b1);
    rc(CTL, EXF | OVF, EXF, EXF);
    rc(CNT, FF, cap, cap + 2);
    chk(timer_irq === 1'b1, "external irq");
    wr(CPR, 32'h00005555);
    wr(CNT, 32'h0000FFFE);
    wr(CTL, RUN | CAPM | EXT);
    repeat (40) @(posedge sys_clk);
    rc(CTL, OVF | EXF, OVF, OVF);
    rd(CNT, d, r);
    chk(d[15:0] < 16'h0008, "no reload in capture");
    pins.trig(1'b0);
    pins.trig(1'b1);
    rc(CTL, EXF, EXF, EXF);
    rc(CPR, FF, d, d + 2);
    wr(CTL, 0);
    wr(MDE, 1 << tmr2_pkg::MOD_DOWN);
    wr(CPR, 32'h00000100);
    wr(CNT, 32'h00000102);
    pins.trig(1'b0);
    wr(CTL, RUN);
    repeat (40) @(posedge sys_clk);
    rc(CTL, OVF | EXF, OVF | EXF, OVF | EXF);
    rc(CNT, FF, 32'h0000FFFC, FF);
    wr(CTL, RUN | EXF);
    repeat (2) @(posedge sys_clk);
    chk(timer_irq === 1'b0, "toggle flag irq");
    pins.trig(1'b1);
    wr(CNT, 32'h0000FFFE);
    repeat (40) @(posedge sys_clk);
    rc(CTL, OVF | EXF, OVF, OVF);
    rc(CNT, FF, 32'h00000100, 32'h00000104);
    wr(CTL, 0);
    for (int i = 0; i < 3; i++) begin
      cap = 16'hFFF0 | 16'($random(seed) & 32'h7);
      wr(CPR, cap);
      wr(CNT, cap);
      wr(MDE, 1 << tmr2_pkg::MOD_CLK_OUT);
      wr(CTL, RUN);
      gap(0, g);
      chk(g == period(cap) && clock_output_pin_oe === 1'b1, "clk out");
      rc(CTL, OVF, 0, 0);
      chk(timer_irq === 1'b0, "clock out irq");
      wr(CTL, RUN | (i[0] ? RXS : TXS));
      gap(i[0] ? 2 : 1, g);
      chk(g * 2 == period(cap), "baud rate");
      wr(CTL, 0);
    end
    g = 0;
    repeat (200) begin
      @(posedge sys_clk);
      if (rx_bit_clock === 1'b1) g++;
    end
    chk(g == 10, "rx clock source");
    summarize();
  end
endmodule

// ---- dv/tmr2_chk_properties.sv ----
// checker: bus handshake and pin timing of tmr2_top
// assumes binding to tmr2_top ports, one sys_clk domain
`timescale 1ns/1ns
module tmr2_chk (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic clock_output_pin_out,
  input wire logic clock_output_pin_oe,
  input wire logic rx_bit_clock,
  input wire logic tx_bit_clock,
  input wire logic timer_irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  sequence wr_taken_s;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken_s;
    s_axi_arvalid && s_axi_arready;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  wr_answer_a: assert property (wr_taken_s |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  rd_answer_a: assert property (rd_taken_s |=> s_axi_rvalid)
    else $error("read answer late");
  wr_stand_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  rd_stand_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  wr_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  rd_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during response");
  clk_half_a: assert property (
    clock_output_pin_oe && $changed(clock_output_pin_out)
    |=> $stable(clock_output_pin_out))
    else $error("clock out half period too short");
  tx_pulse_a: assert property (tx_bit_clock |=> !tx_bit_clock)
    else $error("tx bit clock not a pulse");
  rx_pulse_a: assert property (rx_bit_clock |=> !rx_bit_clock)
    else $error("rx bit clock not a pulse");
  reset_idle_a: assert property ($fell(rst) |-> !timer_irq
    && !clock_output_pin_oe && s_axi_awready && !s_axi_bvalid)
    else $error("not idle after reset");
endmodule
bind tmr2_top tmr2_chk u_chk (.sys_clk, .rst, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .clock_output_pin_out, .clock_output_pin_oe,
  .rx_bit_clock, .tx_bit_clock, .timer_irq);

// ---- dv/tmr2_pin_model.sv ----
// pin model: count input, trigger input and the other timer overflow
// assumes the bench calls its tasks between register accesses
`timescale 1ns/1ns
module tmr2_pin_model (
  input wire logic sys_clk,
  output logic count_pin_in,
  output logic external_trigger_pin,
  output logic other_timer_overflow
);
  int ovf_cnt = 0;
  initial begin
    count_pin_in = 1'b1;
    external_trigger_pin = 1'b1;
    other_timer_overflow = 1'b0;
  end
  // other timer wraps every 20 cycles
  always @(posedge sys_clk) begin
    ovf_cnt <= (ovf_cnt == 19) ? 0 : ovf_cnt + 1;
    other_timer_overflow <= (ovf_cnt == 19);
  end
  task automatic trig(input logic lvl);
    @(posedge sys_clk);
    external_trigger_pin <= lvl;
    repeat (5) @(posedge sys_clk);
  endtask
  task automatic falls(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      count_pin_in <= 1'b0;
      repeat (4) @(posedge sys_clk);
      count_pin_in <= 1'b1;
      repeat (4) @(posedge sys_clk);
    end
  endtask
endmodule

// ---- include/tmr2_pkg.sv ----
// constants for the 16-bit timer/counter with capture, reload and clock-out
// assumes a 10 MHz sys_clk that stands in for the oscillator
package tmr2_pkg;

  localparam int unsigned SYS_CLK_HZ = 10000000;
  localparam int unsigned MACHINE_DIV = 12;
  localparam int unsigned FAST_DIV = 2;
  localparam logic [3:0] PRESCALE_LAST = 4'(MACHINE_DIV - 1);

  localparam logic [15:0] COUNT_TOP = 16'hFFFF;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] CAPTURE_RST = 16'h0000;

  // register byte addresses
  localparam logic [4:0] ADDR_CONTROL = 5'h00;
  localparam logic [4:0] ADDR_MODE = 5'h04;
  localparam logic [4:0] ADDR_COUNT = 5'h08;
  localparam logic [4:0] ADDR_CAPTURE = 5'h0C;
  localparam logic [4:0] ADDR_IRQ_EN = 5'h10;

  // second_timer_control fields
  localparam int unsigned CTL_OVERFLOW = 7;
  localparam int unsigned CTL_EXTERNAL = 6;
  localparam int unsigned CTL_RX_CLK = 5;
  localparam int unsigned CTL_TX_CLK = 4;
  localparam int unsigned CTL_EXT_EN = 3;
  localparam int unsigned CTL_RUN = 2;
  localparam int unsigned CTL_COUNTER = 1;
  localparam int unsigned CTL_CAPTURE = 0;
  localparam logic [7:0] CONTROL_RST = 8'h00;

  // second_timer_mode_control fields
  localparam int unsigned MOD_CLK_OUT = 1;
  localparam int unsigned MOD_DOWN = 0;
  localparam logic [1:0] MODE_RST = 2'h0;

  localparam int unsigned IRQ_EN_BIT = 0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    TMR2_OFF,
    TMR2_RELOAD,
    TMR2_CAPTURE,
    TMR2_BAUD
  } tmr2_mode_t;

endpackage
